// ==== sram_ctl.sv ====
`default_nettype none

module sram_ctl #(
    parameter int SETUP_CYC  = sram_ctl_pkg::SETUP_CYC,
    parameter int WPULSE_CYC = sram_ctl_pkg::WPULSE_CYC,
    parameter int HOLD_CYC   = sram_ctl_pkg::HOLD_CYC,
    parameter int ACCESS_CYC = sram_ctl_pkg::ACCESS_CYC
) (
    input  wire logic                              clk,
    input  wire logic                              rst_n,
    input  wire logic                              reqValid,
    output var  logic                              reqReady,
    input  wire logic                              reqWrite,
    input  wire logic                              reqLatched,
    input  wire logic [sram_ctl_pkg::ADDR_W-1:0]   reqAddr,
    input  wire logic [sram_ctl_pkg::DATA_W-1:0]   reqData,
    input  wire logic [sram_ctl_pkg::BYTES-1:0]    reqByteEn,
    output var  logic                              respValid,
    output var  logic [sram_ctl_pkg::DATA_W-1:0]   respData,
    output var  logic [sram_ctl_pkg::ADDR_W-1:0]   addr,
    output var  logic                              selLow_n,
    output var  logic                              selHigh,
    output var  logic                              writeStrobe_n,
    output var  logic                              low_byte_strobe_n,
    output var  logic                              high_byte_strobe_n,
    output var  logic                              addr_latch_open,
    output var  logic                              wdata_latch_open,
    output var  logic                              outEnable_n,
    input  wire logic [sram_ctl_pkg::DATA_W-1:0]   dataPinsIn,
    output var  logic [sram_ctl_pkg::DATA_W-1:0]   dataPinsOut,
    output var  logic                              dataPinsOe
);

    // ------------------------------------------------------------------
    // State and synchronised read data
    // ------------------------------------------------------------------
    sram_ctl_pkg::ctl_t               st_ff;
    sram_ctl_pkg::ctl_t               nxt_st;
    sram_ctl_pkg::req_t               req;
    logic [sram_ctl_pkg::DATA_W-1:0]  syncData;

    // The pins come from another timing world, so they pass two stages.
    sram_sync2 #(
        .WIDTH (sram_ctl_pkg::DATA_W)
    ) u_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .din   (dataPinsIn),
        .dout  (syncData)
    );

    assign req = '{write: reqWrite, latched: reqLatched, addr: reqAddr,
                   data: reqData, byteEn: reqByteEn};

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    // Every transfer occupies at least three cycles with a fixed address,
    // which covers the cycle time without a separate spacing counter.
    always_comb begin
        nxt_st        = st_ff;
        nxt_st.rvalid = 1'b0;
        unique case (st_ff.phase)
            sram_ctl_pkg::IDLE: begin
                if (reqValid) begin
                    // Address moves only here, with the write strobe high.
                    nxt_st.req                = req;
                    nxt_st.pins.addr          = req.addr;
                    nxt_st.pins.selLow_n      = 1'b0;
                    nxt_st.pins.selHigh       = 1'b1;
                    nxt_st.pins.addrLatchOpen = 1'b1;
                    nxt_st.pins.outEnable_n   = req.write;
                    nxt_st.pins.dataOut       = req.data;
                    nxt_st.pins.dataOe        = req.write;
                    nxt_st.cnt                = 4'(SETUP_CYC - 1);
                    nxt_st.phase              = sram_ctl_pkg::SETUP;
                end
            end
            sram_ctl_pkg::SETUP: begin
                if (st_ff.cnt != 4'h0) begin
                    nxt_st.cnt = st_ff.cnt - 4'h1;
                end else begin
                    // Latch closes only after a full cycle of stable inputs.
                    nxt_st.pins.addrLatchOpen = !st_ff.req.latched;
                    if (st_ff.req.write) begin
                        nxt_st.pins.writeStrobe_n    = 1'b0;
                        nxt_st.pins.lowByteStrobe_n  = !st_ff.req.byteEn[0];
                        nxt_st.pins.highByteStrobe_n = !st_ff.req.byteEn[1];
                        nxt_st.pins.wdataLatchOpen   = !st_ff.req.latched;
                        nxt_st.cnt                   = 4'(WPULSE_CYC - 1);
                        nxt_st.phase                 = sram_ctl_pkg::STROBE;
                    end else begin
                        nxt_st.cnt   = 4'(ACCESS_CYC + sram_ctl_pkg::SYNC_STAGES - 1);
                        nxt_st.phase = sram_ctl_pkg::RWAIT;
                    end
                end
            end
            sram_ctl_pkg::STROBE: begin
                if (st_ff.cnt != 4'h0) begin
                    nxt_st.cnt = st_ff.cnt - 4'h1;
                end else begin
                    // Enables and byte strobes outlast the write strobe.
                    nxt_st.pins.writeStrobe_n = 1'b1;
                    nxt_st.cnt                = 4'(HOLD_CYC - 1);
                    nxt_st.phase              = sram_ctl_pkg::ENDW;
                end
            end
            sram_ctl_pkg::ENDW: begin
                if (st_ff.cnt != 4'h0) begin
                    nxt_st.cnt = st_ff.cnt - 4'h1;
                end else begin
                    nxt_st.pins  = sram_ctl_pkg::PINS_IDLE;
                    nxt_st.pins.addr = st_ff.pins.addr;
                    nxt_st.phase = sram_ctl_pkg::IDLE;
                end
            end
            sram_ctl_pkg::RWAIT: begin
                if (st_ff.cnt != 4'h0) begin
                    nxt_st.cnt = st_ff.cnt - 4'h1;
                end else begin
                    nxt_st.rdata     = syncData;
                    nxt_st.rvalid    = 1'b1;
                    nxt_st.pins      = sram_ctl_pkg::PINS_IDLE;
                    nxt_st.pins.addr = st_ff.pins.addr;
                    nxt_st.phase     = sram_ctl_pkg::IDLE;
                end
            end
            default: begin
                nxt_st = sram_ctl_pkg::CTL_RESET;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_ff <= sram_ctl_pkg::CTL_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign reqReady           = (st_ff.phase == sram_ctl_pkg::IDLE);
    assign respValid          = st_ff.rvalid;
    assign respData           = st_ff.rdata;
    assign addr               = st_ff.pins.addr;
    assign selLow_n           = st_ff.pins.selLow_n;
    assign selHigh            = st_ff.pins.selHigh;
    assign writeStrobe_n      = st_ff.pins.writeStrobe_n;
    assign low_byte_strobe_n  = st_ff.pins.lowByteStrobe_n;
    assign high_byte_strobe_n = st_ff.pins.highByteStrobe_n;
    assign addr_latch_open    = st_ff.pins.addrLatchOpen;
    assign wdata_latch_open   = st_ff.pins.wdataLatchOpen;
    assign outEnable_n        = st_ff.pins.outEnable_n;
    assign dataPinsOut        = st_ff.pins.dataOut;
    assign dataPinsOe         = st_ff.pins.dataOe;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    logic selTrue;
    assign selTrue = !selLow_n && selHigh;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    addr_stable_write_a: assert property (!writeStrobe_n |-> $stable(addr))
        else $error("address moved while write strobe low");
    write_overlap_a: assert property ($fell(writeStrobe_n) |-> selTrue)
        else $error("write strobe fell without enables true");
    write_pulse_a: assert property ($fell(writeStrobe_n) |=>
        $past(selTrue, 2) && selTrue)
        else $error("write pulse or enables too short");
    async_latch_open_a: assert property ((st_ff.phase != sram_ctl_pkg::IDLE &&
        !st_ff.req.latched) |-> (addr_latch_open && wdata_latch_open))
        else $error("latch closed in an asynchronous cycle");
    ale_fall_hold_a: assert property ($fell(addr_latch_open) |->
        $stable(addr) && selTrue ##1 $stable(addr) && selTrue)
        else $error("address not held after latch enable fell");
    ale_pulse_space_a: assert property ($rose(addr_latch_open) |=>
        addr_latch_open ##1 !$rose(addr_latch_open))
        else $error("latch enable rising edges too close");
    addr_spacing_a: assert property ($changed(addr) |=> $stable(addr))
        else $error("address held less than the cycle time");
    data_setup_a: assert property ($rose(writeStrobe_n) |->
        dataPinsOe && $past(dataPinsOe, 2) && $stable(dataPinsOut))
        else $error("write data not valid before write end");
    byte_hold_a: assert property ($rose(writeStrobe_n) |->
        $stable({low_byte_strobe_n, high_byte_strobe_n}) && selTrue)
        else $error("byte strobes not held after write end");
    dle_fall_a: assert property ($fell(wdata_latch_open) |->
        $stable(dataPinsOut) && dataPinsOe ##1 $stable(dataPinsOut) && dataPinsOe)
        else $error("write data not stable around data latch fall");

endmodule : sram_ctl

`default_nettype wire

// ==== sram_ctl_pkg.sv ====
`default_nettype none

package sram_ctl_pkg;

    // ------------------------------------------------------------------
    // Geometry and clock
    // ------------------------------------------------------------------
    localparam int ADDR_W        = 14;
    localparam int DATA_W        = 16;
    localparam int BYTE_W        = 8;
    localparam int BYTES         = 2;
    localparam int SYNC_STAGES   = 2;
    localparam int CLK_PERIOD_NS = 20;

    // ------------------------------------------------------------------
    // Pin timing, slowest grade so that any grade is served
    // ------------------------------------------------------------------
    localparam int T_CYCLE_NS      = 25;
    localparam int T_ALE_HIGH_NS   = 5;
    localparam int T_ADDR_HOLD_NS  = 3;
    localparam int T_WPULSE_NS     = 20;
    localparam int T_DATA_SETUP_NS = 10;
    localparam int T_BS_HOLD_NS    = 2;
    localparam int T_ACCESS_NS     = 25;

    function automatic int cyclesCeil(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : cyclesCeil

    localparam int SETUP_CYC  = cyclesCeil(T_DATA_SETUP_NS > T_ALE_HIGH_NS ?
                                           T_DATA_SETUP_NS : T_ALE_HIGH_NS);
    localparam int WPULSE_CYC = cyclesCeil(T_WPULSE_NS);
    localparam int HOLD_CYC   = cyclesCeil(T_BS_HOLD_NS > T_ADDR_HOLD_NS ?
                                           T_BS_HOLD_NS : T_ADDR_HOLD_NS);
    localparam int ACCESS_CYC = cyclesCeil(T_ACCESS_NS);
    localparam int SPACE_CYC  = cyclesCeil(T_CYCLE_NS);

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        IDLE   = 3'h0,
        SETUP  = 3'h1,
        STROBE = 3'h2,
        ENDW   = 3'h3,
        RWAIT  = 3'h4
    } phase_t;

    typedef struct packed {
        logic              write;
        logic              latched;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic [BYTES-1:0]  byteEn;
    } req_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic              selLow_n;
        logic              selHigh;
        logic              writeStrobe_n;
        logic              lowByteStrobe_n;
        logic              highByteStrobe_n;
        logic              addrLatchOpen;
        logic              wdataLatchOpen;
        logic              outEnable_n;
        logic [DATA_W-1:0] dataOut;
        logic              dataOe;
    } pins_t;

    typedef struct packed {
        phase_t            phase;
        logic [3:0]        cnt;
        req_t              req;
        pins_t             pins;
        logic [DATA_W-1:0] rdata;
        logic              rvalid;
    } ctl_t;

    localparam pins_t PINS_IDLE = '{
        addr:             14'h0000,
        selLow_n:         1'b1,
        selHigh:          1'b0,
        writeStrobe_n:    1'b1,
        lowByteStrobe_n:  1'b1,
        highByteStrobe_n: 1'b1,
        addrLatchOpen:    1'b1,
        wdataLatchOpen:   1'b1,
        outEnable_n:      1'b1,
        dataOut:          16'h0000,
        dataOe:           1'b0
    };

    localparam ctl_t CTL_RESET = '{
        phase:  IDLE,
        cnt:    4'h0,
        req:    '0,
        pins:   PINS_IDLE,
        rdata:  16'h0000,
        rvalid: 1'b0
    };

endpackage : sram_ctl_pkg

`default_nettype wire

// ==== sram_sync2.sv ====
`default_nettype none

module sram_sync2 #(
    parameter int WIDTH = 16
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] din,
    output var  logic [WIDTH-1:0] dout
);

    // First stage feeds only the second one.
    logic [WIDTH-1:0] stage1_ff;
    logic [WIDTH-1:0] stage2_ff;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stage1_ff <= '0;
            stage2_ff <= '0;
        end else begin
            stage1_ff <= din;
            stage2_ff <= stage1_ff;
        end
    end

    assign dout = stage2_ff;

endmodule : sram_sync2

`default_nettype wire

// ==== sram_device_model.sv ====
`default_nettype none

module sram_device_model #(
    parameter int ACC_NS = 25
) (
    input  wire logic [sram_ctl_pkg::ADDR_W-1:0] addr,
    input  wire logic                            selLow_n,
    input  wire logic                            selHigh,
    input  wire logic                            writeStrobe_n,
    input  wire logic                            low_byte_strobe_n,
    input  wire logic                            high_byte_strobe_n,
    input  wire logic                            addr_latch_open,
    input  wire logic                            wdata_latch_open,
    input  wire logic                            outEnable_n,
    input  wire logic [sram_ctl_pkg::DATA_W-1:0] data_pins,
    output var  logic [sram_ctl_pkg::DATA_W-1:0] memOut,
    output var  logic                            memOe
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [15:0]                     mem [0:16383];
    logic [sram_ctl_pkg::ADDR_W-1:0] addrHeld;
    logic                            selLowHeld_n;
    logic                            selHighHeld;
    logic [15:0]                     dataHeld;
    logic                            selTrue;
    logic                            wrLow;
    logic                            wrHigh;

    always_latch begin
        if (addr_latch_open) begin
            addrHeld     <= addr;
            selLowHeld_n <= selLow_n;
            selHighHeld  <= selHigh;
        end
    end

    always_latch begin
        if (wdata_latch_open) begin
            dataHeld <= data_pins;
        end
    end

    assign selTrue = ~selLowHeld_n & selHighHeld;
    assign wrLow   = selTrue & ~writeStrobe_n & ~low_byte_strobe_n;
    assign wrHigh  = selTrue & ~writeStrobe_n & ~high_byte_strobe_n;

    // A byte whose strobe stays high is simply never touched.
    always @* begin
        if (wrLow) begin
            mem[addrHeld][7:0] = dataHeld[7:0];
        end
        if (wrHigh) begin
            mem[addrHeld][15:8] = dataHeld[15:8];
        end
    end

    // Slowest access time, so a controller that samples early reads stale data.
    assign #(ACC_NS) memOut = mem[addrHeld];
    assign #(2) memOe = selTrue & ~outEnable_n & writeStrobe_n;

endmodule : sram_device_model

`default_nettype wire

// ==== tb.sv ====
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        reqValid = 1'b0;
    logic        reqWrite = 1'b0;
    logic        reqLatched = 1'b0;
    logic [13:0] reqAddr = 14'h0000;
    logic [15:0] reqData = 16'h0000;
    logic [1:0]  reqByteEn = 2'h0;
    logic        reqReady, respValid, selLow_n, selHigh, writeStrobe_n, outEnable_n;
    logic        low_byte_strobe_n, high_byte_strobe_n, addr_latch_open, wdata_latch_open;
    logic [15:0] respData, dataPinsOut, memOut, data_pins;
    logic [15:0] floatPat = 16'hA5C3;
    logic [13:0] addr, prevAddr = 14'h0000;
    logic        dataPinsOe, memOe, asyncMode = 1'b0, prevWs = 1'b1;
    int          num_errors = 0;
    int          checks_done = 0;

    always #10 clk = ~clk;
    always @(posedge clk) floatPat <= ~floatPat;

    // Undriven pins show a changing pattern, never the last value.
    assign data_pins = dataPinsOe ? dataPinsOut : (memOe ? memOut : floatPat);

    sram_ctl DUT (.clk(clk), .rst_n(rst_n), .reqValid(reqValid), .reqReady(reqReady),
        .reqWrite(reqWrite), .reqLatched(reqLatched), .reqAddr(reqAddr), .reqData(reqData),
        .reqByteEn(reqByteEn), .respValid(respValid), .respData(respData), .addr(addr),
        .selLow_n(selLow_n), .selHigh(selHigh), .writeStrobe_n(writeStrobe_n),
        .low_byte_strobe_n(low_byte_strobe_n), .high_byte_strobe_n(high_byte_strobe_n),
        .addr_latch_open(addr_latch_open), .wdata_latch_open(wdata_latch_open),
        .outEnable_n(outEnable_n), .dataPinsIn(data_pins), .dataPinsOut(dataPinsOut),
        .dataPinsOe(dataPinsOe));

    sram_device_model MEM (.addr(addr), .selLow_n(selLow_n), .selHigh(selHigh),
        .writeStrobe_n(writeStrobe_n), .low_byte_strobe_n(low_byte_strobe_n),
        .high_byte_strobe_n(high_byte_strobe_n), .addr_latch_open(addr_latch_open),
        .wdata_latch_open(wdata_latch_open), .outEnable_n(outEnable_n),
        .data_pins(data_pins), .memOut(memOut), .memOe(memOe));

    // ------------------------------------------------------------------
    // Pin monitor
    // ------------------------------------------------------------------
    always @(negedge clk) begin
        if (rst_n && addr !== prevAddr && (writeStrobe_n !== 1'b1 || !prevWs)) begin
            num_errors++;
            $display("[FAIL] address moved under write strobe expected 1 seen 0");
        end
        if (rst_n && asyncMode && (addr_latch_open & wdata_latch_open) !== 1'b1) begin
            num_errors++;
            $display("[FAIL] latch open in async cycle expected 1 seen 0");
        end
        if (dataPinsOe === 1'b1 && memOe === 1'b1) begin
            num_errors++;
            $display("[FAIL] pin contention expected 0 seen 1");
        end
        prevAddr = addr;
        prevWs   = writeStrobe_n;
    end

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic doReq(input logic wr, input logic lat, input logic [13:0] a,
                         input logic [15:0] d, input logic [1:0] be, output logic [15:0] rd);
        int n;
        @(posedge clk);
        asyncMode = !lat;
        reqValid   <= 1'b1;
        reqWrite   <= wr;
        reqLatched <= lat;
        reqAddr    <= a;
        reqData    <= d;
        reqByteEn  <= be;
        n = 0;
        do begin @(negedge clk); n++; end while (reqReady !== 1'b1 && n < 20);
        @(posedge clk);
        reqValid <= 1'b0;
        n = 0;
        do begin @(negedge clk); n++; end while ((wr ? reqReady : respValid) !== 1'b1 && n < 20);
        chk("handshake", 16'h0000, {15'h0000, n >= 20});
        rd = respData;
        @(negedge clk);
        asyncMode = 1'b0;
    endtask : doReq

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : give_verdict

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic testReset();
        chk("idle pins", 16'h06FC, {5'h00, reqReady, selLow_n, selHigh, writeStrobe_n,
            low_byte_strobe_n, high_byte_strobe_n, addr_latch_open, wdata_latch_open,
            outEnable_n, dataPinsOe, respValid});
        $display("test reset done");
    endtask : testReset

    task automatic testAsyncWord();
        logic [15:0] rd;
        doReq(1'b1, 1'b0, 14'h0000, 16'hBEEF, 2'h3, rd);
        doReq(1'b0, 1'b0, 14'h0000, 16'h0000, 2'h3, rd);
        chk("async word", 16'hBEEF, rd);
        $display("test async word done");
    endtask : testAsyncWord

    // Byte lanes at the top address, latched, including a fully aborted write.
    task automatic testByteLanes();
        logic [1:0]  be [4]  = '{2'h3, 2'h0, 2'h1, 2'h2};
        logic [15:0] wd [4]  = '{16'hC3D2, 16'h0000, 16'h1234, 16'h5678};
        logic [15:0] exp [4] = '{16'hC3D2, 16'hC3D2, 16'hC334, 16'h5634};
        logic [15:0] rd;
        for (int i = 0; i < 4; i++) begin
            doReq(1'b1, 1'b1, 14'h3FFF, wd[i], be[i], rd);
            doReq(1'b0, 1'b1, 14'h3FFF, 16'h0000, 2'h3, rd);
            chk("byte lane", exp[i], rd);
        end
        doReq(1'b0, 1'b1, 14'h0000, 16'h0000, 2'h3, rd);
        chk("no alias", 16'hBEEF, rd);
        $display("test byte lanes done");
    endtask : testByteLanes

    // Write then read straight away, mixing latched and async cycles.
    task automatic testBackToBack();
        logic [15:0] rd;
        doReq(1'b1, 1'b1, 14'h1555, 16'hA5A5, 2'h3, rd);
        doReq(1'b1, 1'b0, 14'h2AAA, 16'h5A5A, 2'h3, rd);
        doReq(1'b0, 1'b0, 14'h1555, 16'h0000, 2'h3, rd);
        chk("read after write", 16'hA5A5, rd);
        doReq(1'b0, 1'b1, 14'h2AAA, 16'h0000, 2'h3, rd);
        chk("latched read", 16'h5A5A, rd);
        $display("test back to back done");
    endtask : testBackToBack

    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        testReset();
        testAsyncWord();
        testByteLanes();
        testBackToBack();
        give_verdict();
    end

    initial begin
        repeat (5000) @(posedge clk);
        num_errors++;
        give_verdict();
    end

endmodule : tb

`default_nettype wire
